// File: adc_ext_regs.svh
// register map, field positions, reset images and timing constants
`ifndef ADC_EXT_REGS_SVH
`define ADC_EXT_REGS_SVH
`define ADDR_CONFIG 4'h1
`define ADDR_OFFSET 4'h2
`define ADDR_GAIN 4'h3
`define ADDR_FINE 4'hd
`define ADDR_COARSE 4'he
`define ADDR_PATTERN 4'hf
`define RST_CONFIG 16'h92ff
`define RST_OFFSET 16'h007f
`define RST_GAIN 16'h807f
`define RST_FINE 16'h007f
`define RST_COARSE 16'h03ff
`define RST_PATTERN 16'hf7ff
`define ONES_LOW7 16'h007f
`define ONES_CONFIG 16'h80ff
`define ONES_COARSE 16'h03ff
`define ONES_PATTERN 16'hf7ff
`define FRAME_HEADER 12'h001
`define FRAME_LAST 6'h1f
`define CFG_DIFF_SEL 14
`define CFG_TRIM_SKIP 13
`define CFG_SDR 10
`define CFG_EDGE 8
`define OFS_MAG_HI 15
`define OFS_MAG_LO 8
`define OFS_SIGN 7
`define TRIM9_HI 15
`define TRIM9_LO 7
`define CRS_ENABLE 15
`define CRS_MAG_HI 14
`define CRS_MAG_LO 11
`define CRS_LOW_RATE 10
`define PAT_ENABLE 11
`define GAIN_MIN 9'h0c0
`define GAIN_MAX 9'h1c0
`define PAT_WORD 32'h01020304
`define PAT_DELAY_OUTPUT_DATA_CLOCK 4'ha
`define CLK_PERIOD_NS 20
`define SCLK_PERIOD_NS 160
`define SCLK_HALF_CYCLES (`SCLK_PERIOD_NS / `CLK_PERIOD_NS / 2)
`endif

// File: adc_ext_pkg.sv
// shared types of the converter control link
`default_nettype none
package adc_ext_pkg;
  typedef logic [15:0] reg_word_t;
  typedef enum logic [1:0] {OCLK_RUN, OCLK_HOLD, OCLK_RESTART} oclk_state_t;
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} host_state_t;
endpackage : adc_ext_pkg
`default_nettype wire

// File: adc_link_if.sv
// pins between the converter and its controller
`timescale 1ns/100ps
`default_nettype none
interface adc_link_if;
  logic sclk;
  logic sdata;
  logic scs_n;
  logic sync_rst_se;
  logic sync_rst_p;
  logic sync_rst_n;
  logic output_data_clock;
  logic [31:0] data;
  logic ovr;
  logic cal_active;
  modport device_mp (
    input sclk, sdata, scs_n, sync_rst_se, sync_rst_p, sync_rst_n,
    output output_data_clock, data, ovr, cal_active
  );
  modport host_mp (
    output sclk, sdata, scs_n, sync_rst_se, sync_rst_p, sync_rst_n,
    input output_data_clock, data, ovr, cal_active
  );
endinterface : adc_link_if
`default_nettype wire

// File: adc_ext_host.sv
// controller end: serial register writer and sync reset driver
`timescale 1ns/100ps
`default_nettype none
`include "adc_ext_regs.svh"
module adc_ext_host (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // link
  adc_link_if.host_mp LINK,
  // write request
  input wire logic WR_VALID_IN,
  input wire logic [3:0] WR_ADDR_IN,
  input wire adc_ext_pkg::reg_word_t WR_DATA_IN,
  output logic WR_READY_OUT,
  // sync reset request and status
  input wire logic SYNC_REQ_IN,
  output logic SYNC_REFUSED_OUT,
  output logic CAL_ACTIVE_OUT
);
  import adc_ext_pkg::*;
  localparam logic [3:0] SCLK_HALF = 4'(`SCLK_HALF_CYCLES);

  host_state_t state, next_state;
  logic [31:0] frame, next_frame;
  logic [5:0] bit_cnt, next_bit_cnt;
  logic [3:0] div, next_div;
  logic sclk, next_sclk, scs_n, next_scs_n, ready, next_ready;
  logic pend, next_pend, phase_en, next_phase_en;
  reg_word_t cfg, next_cfg;
  logic [1:0] cal_s;
  logic sync_rst, next_sync_rst, refused, next_refused;
  logic pin_se, next_pin_se, pin_p, next_pin_p, pin_n, next_pin_n;
  reg_word_t fixed;
  logic [8:0] gain;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) cal_s <= 2'h0;
    else cal_s <= {cal_s[0], LINK.cal_active};
  end

  always_comb begin
    fixed = WR_DATA_IN;
    gain = WR_DATA_IN[`TRIM9_HI:`TRIM9_LO];
    unique case (WR_ADDR_IN)
      `ADDR_OFFSET, `ADDR_FINE: fixed = WR_DATA_IN | `ONES_LOW7;
      `ADDR_GAIN: begin
        if (gain < `GAIN_MIN) gain = `GAIN_MIN;
        if (gain > `GAIN_MAX) gain = `GAIN_MAX;
        fixed = {gain, 7'h0} | `ONES_LOW7;
      end
      `ADDR_COARSE: fixed = WR_DATA_IN | `ONES_COARSE;
      `ADDR_PATTERN: fixed = WR_DATA_IN | `ONES_PATTERN;
      `ADDR_CONFIG: begin
        fixed = WR_DATA_IN | `ONES_CONFIG;
        if (phase_en) fixed[`CFG_TRIM_SKIP] = 1'b1;
      end
      default: fixed = WR_DATA_IN;
    endcase
  end

  always_comb begin
    next_state = state;
    next_frame = frame;
    next_bit_cnt = bit_cnt;
    next_div = div;
    next_sclk = sclk;
    next_scs_n = scs_n;
    next_pend = pend;
    next_phase_en = phase_en;
    next_cfg = cfg;
    next_ready = 1'b0;
    unique case (state)
      H_IDLE: begin
        next_ready = 1'b1;
        if (WR_VALID_IN && ready) begin
          next_ready = 1'b0;
          next_frame = {`FRAME_HEADER, WR_ADDR_IN, fixed};
          next_bit_cnt = 6'h0;
          next_div = 4'h0;
          next_scs_n = 1'b0;
          next_state = H_LOW;
          if (WR_ADDR_IN == `ADDR_CONFIG) next_cfg = fixed;
          if (WR_ADDR_IN == `ADDR_COARSE) begin
            next_phase_en = fixed[`CRS_ENABLE];
            next_pend = fixed[`CRS_ENABLE] && !cfg[`CFG_TRIM_SKIP];
          end
        end
      end
      H_LOW: begin
        next_div = div + 4'h1;
        if (div == SCLK_HALF - 4'h1) begin
          next_div = 4'h0;
          next_sclk = 1'b1;
          next_state = H_HIGH;
        end
      end
      H_HIGH: begin
        next_div = div + 4'h1;
        if (div == SCLK_HALF - 4'h1) begin
          next_div = 4'h0;
          next_sclk = 1'b0;
          next_state = H_LOW;
          next_bit_cnt = bit_cnt + 6'h1;
          next_frame = {frame[30:0], 1'b0};
          if (bit_cnt == `FRAME_LAST) begin
            next_bit_cnt = 6'h0;
            if (pend) begin
              // follow the coarse write with the trim-skip configuration
              next_pend = 1'b0;
              next_cfg = cfg | (16'h1 << `CFG_TRIM_SKIP);
              next_frame = {`FRAME_HEADER, `ADDR_CONFIG, next_cfg};
            end else begin
              next_scs_n = 1'b1;
              next_state = H_IDLE;
            end
          end
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_comb begin
    next_sync_rst = sync_rst;
    next_refused = 1'b0;
    if (!SYNC_REQ_IN) next_sync_rst = 1'b0;
    else if (!sync_rst) begin
      next_sync_rst = !cal_s[1];
      next_refused = cal_s[1];
    end
    // pins come from flops so a config change cannot glitch them
    next_pin_se = next_sync_rst & ~next_cfg[`CFG_DIFF_SEL];
    next_pin_p = next_sync_rst & next_cfg[`CFG_DIFF_SEL];
    next_pin_n = ~next_sync_rst & next_cfg[`CFG_DIFF_SEL];
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state <= H_IDLE;
      frame <= 32'h0;
      bit_cnt <= 6'h0;
      div <= 4'h0;
      sclk <= 1'b0;
      scs_n <= 1'b1;
      ready <= 1'b0;
      pend <= 1'b0;
      phase_en <= 1'b0;
      cfg <= `RST_CONFIG;
      sync_rst <= 1'b0;
      refused <= 1'b0;
      pin_se <= 1'b0;
      pin_p <= 1'b0;
      pin_n <= 1'b0;
    end else begin
      state <= next_state;
      frame <= next_frame;
      bit_cnt <= next_bit_cnt;
      div <= next_div;
      sclk <= next_sclk;
      scs_n <= next_scs_n;
      ready <= next_ready;
      pend <= next_pend;
      phase_en <= next_phase_en;
      cfg <= next_cfg;
      sync_rst <= next_sync_rst;
      refused <= next_refused;
      pin_se <= next_pin_se;
      pin_p <= next_pin_p;
      pin_n <= next_pin_n;
    end
  end

  assign LINK.sclk = sclk;
  assign LINK.sdata = frame[31];
  assign LINK.scs_n = scs_n;
  // unused sync input pair is held grounded
  assign LINK.sync_rst_se = pin_se;
  assign LINK.sync_rst_p = pin_p;
  assign LINK.sync_rst_n = pin_n;
  assign WR_READY_OUT = ready;
  assign SYNC_REFUSED_OUT = refused;
  assign CAL_ACTIVE_OUT = cal_s[1];
endmodule : adc_ext_host
`default_nettype wire

// File: adc_ext_device.sv
// converter end: extended control registers, output clock sync, test pattern
// Operation
// - offset: magnitude 15:8, sign bit 7
// - controller writes ones to unused low bits
// - gain 9-bit trim in bits 15:7
// - controller keeps gain within recommended range
// - new gain applies without recalibration
// - fine delay 9-bit magnitude, resets zero
// - phase enable bit 15; controller sets trim-skip
// - coarse delay magnitude bits 14:11
// - bit 10 selects low-rate clock mode
// - pattern enable drives outputs from generator
// - configuration bit selects differential sync input
// - sync reset holds output clock fixed
// - release realigns output clock after delay
// - output clock stops during calibration unless trim-skip is set
// - no sync reset while calibration active
// - 32-bit frame: header, address, data
// - extended registers act only in extended mode
// - pattern appears ten output clocks after write
// - pattern alternates words and flag
`timescale 1ns/100ps
`default_nettype none
`include "adc_ext_regs.svh"
module adc_ext_device #(
  parameter logic [7:0] OUTPUT_DATA_CLOCK_HALF = 8'h2,
  parameter logic [7:0] SYNC_DELAY = 8'h4,
  parameter logic [15:0] CAL_CYCLES = 16'h0400
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // link
  adc_link_if.device_mp LINK,
  // converter side
  input wire logic EXT_MODE_IN,
  input wire logic CAL_START_IN,
  input wire logic [31:0] SAMPLE_IN,
  input wire logic SAMPLE_OVR_IN,
  // trim settings
  output logic [7:0] OFFSET_MAG_OUT,
  output logic OFFSET_NEG_OUT,
  output logic [8:0] GAIN_OUT,
  output logic [8:0] FINE_DELAY_OUT,
  output logic [3:0] COARSE_DELAY_OUT,
  output logic PHASE_ADJ_EN_OUT,
  output logic LOW_RATE_OUT,
  output logic PATTERN_ON_OUT,
  output logic DIFF_SYNC_OUT
);
  import adc_ext_pkg::*;

  logic [1:0] sclk_s, sdata_s, scs_s, se_s, p_s, n_s;
  logic sclk_d;
  logic sclk_rise, sync_req;

  // serial receiver and register file
  logic [31:0] shift, next_shift;
  logic [5:0] bit_cnt, next_bit_cnt;
  reg_word_t cfg, ofs, gain, fine, crs, pat;
  reg_word_t next_cfg, next_ofs, next_gain, next_fine, next_crs, next_pat;
  logic pat_wr;
  reg_word_t cfg_e, ofs_e, gain_e, fine_e, crs_e, pat_e;

  // output clock and calibration
  oclk_state_t state, next_state;
  logic [7:0] div, next_div, dly, next_dly;
  logic output_data_clock, next_output_data_clock, output_data_clock_rise;
  logic hold_level, run_ok;
  logic [15:0] cal_cnt, next_cal_cnt;
  logic cal_active, next_cal_active;

  // data path
  logic [3:0] pat_cnt, next_pat_cnt;
  logic pat_on, next_pat_on, phase, next_phase;
  logic [31:0] data, next_data;
  logic ovr, next_ovr;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sclk_s <= 2'h0;
      sdata_s <= 2'h0;
      scs_s <= 2'h3;
      se_s <= 2'h0;
      p_s <= 2'h0;
      n_s <= 2'h0;
      sclk_d <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], LINK.sclk};
      sdata_s <= {sdata_s[0], LINK.sdata};
      scs_s <= {scs_s[0], LINK.scs_n};
      se_s <= {se_s[0], LINK.sync_rst_se};
      p_s <= {p_s[0], LINK.sync_rst_p};
      n_s <= {n_s[0], LINK.sync_rst_n};
      sclk_d <= sclk_s[1];
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_d;

  // outside extended mode every register reads as its power-on image
  assign cfg_e = EXT_MODE_IN ? cfg : `RST_CONFIG;
  assign ofs_e = EXT_MODE_IN ? ofs : `RST_OFFSET;
  assign gain_e = EXT_MODE_IN ? gain : `RST_GAIN;
  assign fine_e = EXT_MODE_IN ? fine : `RST_FINE;
  assign crs_e = EXT_MODE_IN ? crs : `RST_COARSE;
  assign pat_e = EXT_MODE_IN ? pat : `RST_PATTERN;

  assign sync_req = cfg_e[`CFG_DIFF_SEL] ? (p_s[1] & ~n_s[1]) : se_s[1];

  always_comb begin
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_cfg = cfg;
    next_ofs = ofs;
    next_gain = gain;
    next_fine = fine;
    next_crs = crs;
    next_pat = pat;
    pat_wr = 1'b0;
    if (scs_s[1] || !EXT_MODE_IN) next_bit_cnt = 6'h0;
    else if (sclk_rise) begin
      next_shift = {shift[30:0], sdata_s[1]};
      next_bit_cnt = bit_cnt + 6'h1;
      if (bit_cnt == `FRAME_LAST) begin
        next_bit_cnt = 6'h0;
        if (next_shift[31:20] == `FRAME_HEADER) begin
          unique case (next_shift[19:16])
            `ADDR_CONFIG: next_cfg = next_shift[15:0];
            `ADDR_OFFSET: next_ofs = next_shift[15:0];
            `ADDR_GAIN: next_gain = next_shift[15:0];
            `ADDR_FINE: next_fine = next_shift[15:0];
            `ADDR_COARSE: next_crs = next_shift[15:0];
            `ADDR_PATTERN: begin
              next_pat = next_shift[15:0];
              pat_wr = 1'b1;
            end
            default: next_shift = next_shift;
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      shift <= 32'h0;
      bit_cnt <= 6'h0;
      cfg <= `RST_CONFIG;
      ofs <= `RST_OFFSET;
      gain <= `RST_GAIN;
      fine <= `RST_FINE;
      crs <= `RST_COARSE;
      pat <= `RST_PATTERN;
      OFFSET_MAG_OUT <= 8'h0;
      OFFSET_NEG_OUT <= 1'b0;
      GAIN_OUT <= 9'h0;
      FINE_DELAY_OUT <= 9'h0;
      COARSE_DELAY_OUT <= 4'h0;
      PHASE_ADJ_EN_OUT <= 1'b0;
      LOW_RATE_OUT <= 1'b0;
      DIFF_SYNC_OUT <= 1'b0;
    end else begin
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      cfg <= next_cfg;
      ofs <= next_ofs;
      gain <= next_gain;
      fine <= next_fine;
      crs <= next_crs;
      pat <= next_pat;
      OFFSET_MAG_OUT <= ofs_e[`OFS_MAG_HI:`OFS_MAG_LO];
      OFFSET_NEG_OUT <= ofs_e[`OFS_SIGN];
      // gain follows the register directly, no calibration pass
      GAIN_OUT <= gain_e[`TRIM9_HI:`TRIM9_LO];
      FINE_DELAY_OUT <= fine_e[`TRIM9_HI:`TRIM9_LO];
      COARSE_DELAY_OUT <= crs_e[`CRS_MAG_HI:`CRS_MAG_LO];
      PHASE_ADJ_EN_OUT <= crs_e[`CRS_ENABLE];
      LOW_RATE_OUT <= crs_e[`CRS_LOW_RATE];
      DIFF_SYNC_OUT <= cfg_e[`CFG_DIFF_SEL];
    end
  end

  // held level: low in double rate, opposite of the launch edge in single rate
  assign hold_level = cfg_e[`CFG_SDR] & ~cfg_e[`CFG_EDGE];
  assign run_ok = !cal_active || cfg_e[`CFG_TRIM_SKIP];

  always_comb begin
    next_state = state;
    next_div = div;
    next_dly = dly;
    next_output_data_clock = output_data_clock;
    output_data_clock_rise = 1'b0;
    next_cal_cnt = cal_cnt;
    next_cal_active = cal_active;
    if (cal_active) begin
      next_cal_cnt = cal_cnt - 16'h1;
      if (cal_cnt == 16'h0) next_cal_active = 1'b0;
    end else if (CAL_START_IN) begin
      next_cal_active = 1'b1;
      next_cal_cnt = CAL_CYCLES - 16'h1;
    end
    unique case (state)
      OCLK_RUN: begin
        if (sync_req) begin
          next_state = OCLK_HOLD;
          next_output_data_clock = hold_level;
        end else if (run_ok) begin
          next_div = div + 8'h1;
          if (div == OUTPUT_DATA_CLOCK_HALF - 8'h1) begin
            next_div = 8'h0;
            next_output_data_clock = !output_data_clock;
            output_data_clock_rise = !output_data_clock;
          end
        end else begin
          next_output_data_clock = 1'b0;
          next_div = 8'h0;
        end
      end
      OCLK_HOLD: begin
        next_output_data_clock = hold_level;
        if (!sync_req) begin
          // release seen on a clock edge realigns the divider phase
          next_state = OCLK_RESTART;
          next_dly = 8'h0;
          next_div = 8'h0;
        end
      end
      OCLK_RESTART: begin
        next_dly = dly + 8'h1;
        if (sync_req) next_state = OCLK_HOLD;
        else if (dly == SYNC_DELAY - 8'h1) next_state = OCLK_RUN;
      end
      default: next_state = OCLK_RUN;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state <= OCLK_RUN;
      div <= 8'h0;
      dly <= 8'h0;
      output_data_clock <= 1'b0;
      cal_cnt <= 16'h0;
      cal_active <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      dly <= next_dly;
      output_data_clock <= next_output_data_clock;
      cal_cnt <= next_cal_cnt;
      cal_active <= next_cal_active;
    end
  end

  always_comb begin
    next_pat_cnt = pat_cnt;
    next_pat_on = pat_on;
    next_phase = phase;
    next_data = data;
    next_ovr = ovr;
    if (pat_wr) next_pat_cnt = `PAT_DELAY_OUTPUT_DATA_CLOCK;
    else if (output_data_clock_rise && pat_cnt != 4'h0) next_pat_cnt = pat_cnt - 4'h1;
    if (pat_cnt == 4'h0 && !pat_wr) next_pat_on = pat_e[`PAT_ENABLE];
    if (!EXT_MODE_IN) next_pat_on = 1'b0;
    if (output_data_clock_rise) begin
      if (pat_on) begin
        next_phase = !phase;
        next_data = phase ? ~`PAT_WORD : `PAT_WORD;
        next_ovr = phase;
      end else begin
        next_phase = 1'b0;
        next_data = SAMPLE_IN;
        next_ovr = SAMPLE_OVR_IN;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pat_cnt <= 4'h0;
      pat_on <= 1'b0;
      phase <= 1'b0;
      data <= 32'h0;
      ovr <= 1'b0;
    end else begin
      pat_cnt <= next_pat_cnt;
      pat_on <= next_pat_on;
      phase <= next_phase;
      data <= next_data;
      ovr <= next_ovr;
    end
  end

  assign LINK.output_data_clock = output_data_clock;
  assign LINK.data = data;
  assign LINK.ovr = ovr;
  assign LINK.cal_active = cal_active;
  assign PATTERN_ON_OUT = pat_on;
endmodule : adc_ext_device
`default_nettype wire

// File: adc_ext_monitor.sv
// concurrent checks on the converter control link
`timescale 1ns/100ps
`default_nettype none
module adc_ext_monitor #(
  parameter logic [15:0] CAL_CYCLES = 16'h0400
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // link signals
  input wire logic sclk,
  input wire logic sdata,
  input wire logic scs_n,
  input wire logic sync_rst_se,
  input wire logic sync_rst_p,
  input wire logic sync_rst_n,
  input wire logic output_data_clock,
  input wire logic [31:0] data,
  input wire logic ovr,
  input wire logic cal_active
);
  logic sclk_d;
  logic next_sclk_d;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [15:0] cal_len;
  logic [15:0] next_cal_len;
  logic rise;
  logic sync_on;
  assign rise = sclk & ~sclk_d;
  assign sync_on = sync_rst_se | (sync_rst_p & ~sync_rst_n);
  // bit index within a frame and length of the calibration window
  always_comb begin
    next_sclk_d = sclk;
    next_bit_cnt = scs_n ? 5'h00 : bit_cnt + {4'h0, rise};
    next_cal_len = cal_active ? cal_len + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sclk_d <= 1'b0;
      bit_cnt <= 5'h00;
      cal_len <= 16'h0000;
    end else begin
      sclk_d <= next_sclk_d;
      bit_cnt <= next_bit_cnt;
      cal_len <= next_cal_len;
    end
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  frame_idle_a: assert property (scs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  frame_header_a: assert property (rise & (bit_cnt < 5'hc) |-> sdata == (bit_cnt == 5'hb))
    else $error("frame header bit wrong");
  sclk_high_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase wrong");
  sync_select_a: assert property (sync_rst_se |-> !sync_rst_p && !sync_rst_n)
    else $error("both sync inputs driven");
  sync_hold_a: assert property (sync_on[*5] |-> $stable(output_data_clock))
    else $error("output clock moved during sync reset");
  sync_restart_a: assert property ($fell(sync_on) |=> $stable(output_data_clock)[*3] ##[1:12] $rose(output_data_clock))
    else $error("output clock restart wrong");
  no_cal_sync_a: assert property ($rose(sync_on) |-> !($past(cal_active, 3) && $past(cal_active, 4)))
    else $error("sync reset raised during calibration");
  cal_length_a: assert property ($fell(cal_active) |-> cal_len == CAL_CYCLES)
    else $error("calibration window length wrong");
  pattern_flag_a: assert property ((data == 32'h01020304 || data == 32'hfefdfcfb) |-> ovr == data[31])
    else $error("pattern flag wrong");
  data_on_output_data_clock_a: assert property ($changed(data) |-> $rose(output_data_clock))
    else $error("data changed off an output clock rise");
  cover property (rise && bit_cnt == 5'h1f);
  cover property ($fell(sync_on));
  cover property ($fell(cal_active));
  cover property (data == 32'hfefdfcfb && ovr);
endmodule : adc_ext_monitor
`default_nettype wire

// File: adc_extended_control_registers_bench.sv
// self-checking bench joining the controller and converter ends
`timescale 1ns/100ps
`default_nettype none
module adc_extended_control_registers_bench;
  import adc_ext_pkg::*;
  localparam logic [15:0] CALN = 16'h0010;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_valid = 1'b0;
  logic [3:0] wr_addr = 4'h0;
  reg_word_t wr_data = 16'h0000;
  logic sync_req = 1'b0;
  logic ext_mode = 1'b0;
  logic cal_start = 1'b0;
  logic [31:0] sample = 32'h00000000;
  logic sample_ovr = 1'b0;
  logic wr_ready, refused, cal_seen, pat_on, phase_en, low_rate, diff_sync, ofs_neg;
  logic [7:0] ofs_mag;
  logic [8:0] gain, fine, e_gain;
  logic [3:0] coarse;
  logic [31:0] seed = 32'h00012913; // 76051
  logic [31:0] r;
  reg_word_t e_ofs, e_fine, e_crs, gw;
  logic pw;
  logic [31:0] sample_q;
  logic ovr_q;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n, ups;
  always #10 clk = ~clk;
  adc_link_if link ();
  adc_ext_host adc_ext_host_inst (.CLK_IN(clk), .RSTN_IN(rstn), .LINK(link.host_mp),
    .WR_VALID_IN(wr_valid), .WR_ADDR_IN(wr_addr), .WR_DATA_IN(wr_data), .WR_READY_OUT(wr_ready),
    .SYNC_REQ_IN(sync_req), .SYNC_REFUSED_OUT(refused), .CAL_ACTIVE_OUT(cal_seen));
  adc_ext_device #(.OUTPUT_DATA_CLOCK_HALF(8'h2), .SYNC_DELAY(8'h4), .CAL_CYCLES(CALN)) adc_ext_device_inst (
    .CLK_IN(clk), .RSTN_IN(rstn), .LINK(link.device_mp), .EXT_MODE_IN(ext_mode),
    .CAL_START_IN(cal_start), .SAMPLE_IN(sample), .SAMPLE_OVR_IN(sample_ovr),
    .OFFSET_MAG_OUT(ofs_mag), .OFFSET_NEG_OUT(ofs_neg), .GAIN_OUT(gain), .FINE_DELAY_OUT(fine),
    .COARSE_DELAY_OUT(coarse), .PHASE_ADJ_EN_OUT(phase_en), .LOW_RATE_OUT(low_rate),
    .PATTERN_ON_OUT(pat_on), .DIFF_SYNC_OUT(diff_sync));
  adc_ext_monitor #(.CAL_CYCLES(CALN)) adc_ext_monitor_inst (.CLK_IN(clk), .RSTN_IN(rstn),
    .sclk(link.sclk), .sdata(link.sdata), .scs_n(link.scs_n), .sync_rst_se(link.sync_rst_se),
    .sync_rst_p(link.sync_rst_p), .sync_rst_n(link.sync_rst_n), .output_data_clock(link.output_data_clock),
    .data(link.data), .ovr(link.ovr), .cal_active(link.cal_active));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // gain is clamped into the recommended window
  function automatic logic [8:0] gain_exp(input reg_word_t d);
    if (d[15:7] < 9'h0c0) return 9'h0c0;
    if (d[15:7] > 9'h1c0) return 9'h1c0;
    return d[15:7];
  endfunction : gain_exp
  always @(posedge clk) begin
    sample <= #1 rnd();
    sample_ovr <= #1 seed[3];
    // converter word as the device takes it at this edge
    sample_q <= sample;
    ovr_q <= sample_ovr;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wait_ready();
    int k;
    k = 0;
    while (wr_ready !== 1'b1 && k < 1000) begin
      tick(1);
      k++;
    end
    chk(wr_ready, 1'b1, "write ready");
  endtask : wait_ready
  task automatic wr(input logic [3:0] a, input reg_word_t d);
    wait_ready();
    wr_addr = a;
    wr_data = d;
    wr_valid = 1'b1;
    tick(1);
    wr_valid = 1'b0;
    tick(3);
    wait_ready();
  endtask : wr
  task automatic chk_trims();
    tick(8);
    chk(ofs_mag, e_ofs[15:8], "offset");
    chk(ofs_neg, e_ofs[7], "offset sign");
    chk(gain, e_gain, "gain");
    chk(fine, e_fine[15:7], "fine delay");
    chk(coarse, e_crs[14:11], "coarse delay");
    chk(low_rate, e_crs[10], "low rate");
    chk(phase_en, e_crs[15], "phase enable");
  endtask : chk_trims
  task automatic next_rise();
    logic p;
    int k;
    k = 0;
    p = link.output_data_clock;
    tick(1);
    while (!(link.output_data_clock === 1'b1 && p === 1'b0) && k < 20) begin
      p = link.output_data_clock;
      tick(1);
      k++;
    end
  endtask : next_rise
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      $display("Error %0t: run did not finish", $time);
      final_report();
    end
  end
  initial begin
    e_ofs = 16'h0000;
    e_gain = 9'h100;
    e_fine = 16'h0000;
    e_crs = 16'h0000;
    tick(4);
    rstn = 1'b1;
    chk_trims();
    wr(4'h2, 16'hab7f);
    chk_trims();
    ext_mode = 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      e_ofs = (i == 0) ? 16'hff80 : r[15:0];
      e_fine = (i == 1) ? 16'hffff : r[31:16];
      r = rnd();
      gw = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : r[15:0];
      e_gain = gain_exp(gw);
      e_crs = {1'b0, r[30:16]};
      wr(4'h2, e_ofs);
      wr(4'h3, gw);
      wr(4'hd, e_fine);
      wr(4'he, e_crs);
      chk_trims();
    end
    wr(4'h1, 16'hd2ff);
    tick(8);
    chk(diff_sync, 1'b1, "differential select");
    sync_req = 1'b1;
    tick(12);
    chk({link.sync_rst_se, link.sync_rst_p, link.sync_rst_n}, 3'b010, "sync pins");
    chk(link.output_data_clock, 1'b0, "held output clock");
    sync_req = 1'b0;
    n = 0;
    while (link.output_data_clock !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(n >= 6 && n <= 14, 1'b1, "restart delay");
    // single-ended, single rate, falling launch edge: clock held high
    wr(4'h1, 16'h96ff);
    tick(8);
    chk(diff_sync, 1'b0, "single-ended select");
    sync_req = 1'b1;
    tick(6);
    chk({link.sync_rst_se, link.sync_rst_p, link.sync_rst_n}, 3'b100, "sync pins");
    chk(link.output_data_clock, 1'b1, "held output clock high");
    sync_req = 1'b0;
    tick(20);
    cal_start = 1'b1;
    tick(1);
    cal_start = 1'b0;
    tick(4);
    chk(cal_seen, 1'b1, "calibration status");
    sync_req = 1'b1;
    n = 0;
    ups = 0;
    repeat (10) begin
      tick(1);
      if (refused === 1'b1) n++;
      if (link.output_data_clock !== 1'b0) ups++;
    end
    chk(n > 0, 1'b1, "sync refused");
    chk(link.sync_rst_se, 1'b0, "sync withheld");
    chk(ups, 0, "output clock stopped");
    sync_req = 1'b0;
    tick(20);
    wr(4'hf, 16'hffff);
    n = 0;
    for (int k = 0; k < 14 && pat_on !== 1'b1; k++) begin
      next_rise();
      n++;
    end
    chk(n >= 8 && n <= 11, 1'b1, "pattern delay");
    next_rise();
    pw = link.data[31];
    chk(link.data === 32'h01020304 || link.data === 32'hfefdfcfb, 1'b1, "pattern word");
    repeat (4) begin
      next_rise();
      pw = ~pw;
      chk(link.data, pw ? 32'hfefdfcfb : 32'h01020304, "pattern");
      chk(link.ovr, pw, "pattern flag");
    end
    wr(4'hf, 16'hf7ff);
    repeat (12) next_rise();
    chk(pat_on, 1'b0, "pattern off");
    next_rise();
    chk(link.data, sample_q, "converter data");
    chk(link.ovr, ovr_q, "converter flag");
    e_crs = 16'hffff;
    wr(4'he, e_crs);
    chk_trims();
    cal_start = 1'b1;
    tick(1);
    cal_start = 1'b0;
    ups = 0;
    repeat (14) begin
      tick(1);
      if (link.output_data_clock === 1'b1) ups++;
    end
    chk(ups > 0, 1'b1, "output clock kept");
    tick(20);
    final_report();
  end
endmodule : adc_extended_control_registers_bench
`default_nettype wire
